/* File: ufl_top.sv */
// Serial port FIFO control and line control with Avalon-MM registers.
// Notes on behaviour
// - Receive threshold code sets data-available level.
// - Receive DMA request follows receive threshold in DMA mode 1 or extended handshake.
// - Transmit threshold code sets empty interrupt level.
// - Transmit DMA request follows transmit threshold in DMA mode 1 or extended handshake.
// - One bit picks DMA mode 0 or 1.
// - Transmit FIFO reset empties, drops requests, self-clears.
// - Receive FIFO reset empties, drops requests, self-clears.
// - Toggling FIFO enable resets both FIFOs.
// - Divisor access opens divisor bytes; software clears.
// - Break outside loopback holds serial output low.
// - Break in infrared mode pulses infrared output.
// - Loopback break goes internal; infrared output low.
// - Parity sense set means even, clear odd.
// - Parity enable switches generation and checking.
// - Divisor access and parity bits change when idle.
// - Modem bit selects loopback diagnostic mode.
// - Modem bit selects infrared serial mode.
module ufl_top import ufl_pkg::*; #(
  parameter int DEPTH = 16, // FIFO capacity in characters.
  parameter int LW = 5, // Level width, at most eight.
  parameter int IR_HALF = UFL_IR_HALF_CYC // Break pulse half period.
) (
  input wire logic clk_sys, // System clock, 20 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [7:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall.
  input wire logic busy, // Port is busy.
  input wire logic rx_push, // Character received.
  input wire logic rx_pop, // Character read out.
  input wire logic tx_push, // Character written.
  input wire logic tx_pop, // Character sent.
  input wire logic tx_bit, // Transmitter line level.
  output logic [LW-1:0] rx_level, // Receive fill level.
  output logic [LW-1:0] tx_level, // Transmit fill level.
  output logic rx_avail_int, // Receive data available.
  output logic thre_int, // Transmit empty event.
  output logic rts_n, // Request to send, active low.
  output logic dma_rx_req_n, // Receive DMA request.
  output logic dma_tx_req_n, // Transmit DMA request.
  output logic dma_rx_single_n, // Receive single request.
  output logic dma_tx_single_n, // Transmit single request.
  output logic ser_out, // Serial output.
  output logic ir_out_n, // Infrared output.
  output logic loop_line, // Loopback line to receiver.
  output logic parity_on_bit, // Parity enabled.
  output logic parity_even, // Even parity selected.
  output logic [15:0] baud_divisor // Baud divisor.
);
  // Register state and the bus, interrupt and DMA outputs; levels and line outputs sit in submodules.
  typedef struct packed {
    logic wr; // Wait request.
    logic [31:0] rdata; // Read data.
    logic fifo_en; // FIFOs on.
    logic [1:0] rx_thr; // Receive threshold code.
    logic [1:0] tx_thr; // Transmit threshold code.
    logic dma_mode; // DMA mode 1.
    logic rx_rst; // Receive reset pulse.
    logic tx_rst; // Transmit reset pulse.
    logic dlab; // Divisor access.
    logic brk; // Break.
    logic even; // Even parity.
    logic par_on; // Parity on.
    logic ir; // Infrared mode.
    logic afc; // Auto flow control.
    logic loop; // Loopback.
    logic rts; // Request to send.
    logic pthre; // Programmable empty mode.
    logic ext_hs; // Extended handshake.
    logic [15:0] div; // Divisor.
    logic rx_on; // Receive request held.
    logic tx_on; // Transmit request held.
    logic rx_int; // Receive interrupt.
    logic thre; // Empty interrupt.
    logic rts_n; // Request to send out.
    logic rx_req_n; // Receive request out.
    logic tx_req_n; // Transmit request out.
    logic rx_sgl_n; // Receive single out.
    logic tx_sgl_n; // Transmit single out.
  } ufl_top_s;
  ufl_top_s s, next_s; // State and its next value.

  logic [LW-1:0] cap; // Capacity in use.
  logic [LW-1:0] rx_mark; // Receive trigger level.
  logic [LW-1:0] tx_mark; // Transmit trigger level.
  logic rx_hit; // Receive level reached.
  logic tx_low; // Transmit level low enough.
  logic rx_go; // Receive request wanted.
  logic tx_go; // Transmit request wanted.
  logic acc_w; // Write taken this cycle.
  logic [7:0] wd; // Low write byte.

  // Receive trigger level for a threshold code.
  function automatic logic [LW-1:0] rx_mark_f(input logic [1:0] c);
    case (c)
      2'h0: rx_mark_f = LW'(1);
      2'h1: rx_mark_f = LW'(DEPTH / 4);
      2'h2: rx_mark_f = LW'(DEPTH / 2);
      default: rx_mark_f = LW'(DEPTH - 2);
    endcase
  endfunction

  // Transmit empty level for a threshold code.
  function automatic logic [LW-1:0] tx_mark_f(input logic [1:0] c);
    case (c)
      2'h0: tx_mark_f = '0;
      2'h1: tx_mark_f = LW'(2);
      2'h2: tx_mark_f = LW'(DEPTH / 4);
      default: tx_mark_f = LW'(DEPTH / 2);
    endcase
  endfunction

  // Both FIFO level trackers share one module.
  ufl_fifo_lvl #(.DEPTH(DEPTH), .LW(LW)) u_rx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clr(s.rx_rst),
    .push(rx_push),
    .pop(rx_pop),
    .cap(cap),
    .level(rx_level)
  );
  ufl_fifo_lvl #(.DEPTH(DEPTH), .LW(LW)) u_tx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clr(s.tx_rst),
    .push(tx_push),
    .pop(tx_pop),
    .cap(cap),
    .level(tx_level)
  );

  // Line output stage for break, infrared and loopback.
  ufl_line_out #(.HALF(IR_HALF)) u_line (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tx_bit(tx_bit),
    .brk(s.brk),
    .loop(s.loop),
    .ir_on(s.ir),
    .ser_out(ser_out),
    .ir_out_n(ir_out_n),
    .loop_line(loop_line)
  );

  // Thresholds and request conditions from the current levels.
  always_comb begin
    cap = s.fifo_en ? LW'(DEPTH) : LW'(1);
    rx_mark = s.fifo_en ? rx_mark_f(s.rx_thr) : LW'(1);
    tx_mark = s.fifo_en ? tx_mark_f(s.tx_thr) : '0;
    rx_hit = (rx_level >= rx_mark);
    tx_low = (s.pthre && s.fifo_en) ? (tx_level <= tx_mark) : (tx_level == '0);
    rx_go = rx_hit || (s.rx_on && rx_level != '0);
    tx_go = (tx_level <= tx_mark) || (s.tx_on && tx_level != cap);
  end

  // Bus slave, register writes and registered outputs.
  always_comb begin
    next_s = s;
    acc_w = avs_write && !s.wr && avs_byteenable[0];
    wd = avs_writedata[7:0];
    next_s.rx_rst = 1'b0;
    next_s.tx_rst = 1'b0;
    // Answer one cycle after a request is seen.
    if ((avs_read || avs_write) && s.wr) begin
      next_s.wr = 1'b0;
      next_s.rdata = '0;
      if (avs_read) begin
        case (avs_address)
          UFL_DIV_LO_OFS: next_s.rdata[7:0] = s.dlab ? s.div[7:0] : 8'h00;
          UFL_DIV_HI_OFS: next_s.rdata[7:0] = s.dlab ? s.div[15:8] : 8'h00;
          UFL_FIFO_CTRL_OFS: next_s.rdata[7:6] = {2{s.fifo_en}};
          UFL_LINE_CTRL_OFS: begin
            next_s.rdata[UFL_LC_DLAB] = s.dlab;
            next_s.rdata[UFL_LC_BRK] = s.brk;
            next_s.rdata[UFL_LC_EVEN] = s.even;
            next_s.rdata[UFL_LC_PAR] = s.par_on;
          end
          UFL_MODEM_OFS: begin
            next_s.rdata[UFL_MC_IR] = s.ir;
            next_s.rdata[UFL_MC_AFC] = s.afc;
            next_s.rdata[UFL_MC_LOOP] = s.loop;
            next_s.rdata[UFL_MC_RTS] = s.rts;
          end
          UFL_DMA_CFG_OFS: begin
            next_s.rdata[UFL_DC_PTHRE] = s.pthre;
            next_s.rdata[UFL_DC_EXT] = s.ext_hs;
          end
          UFL_STAT_OFS: begin
            next_s.rdata[UFL_ST_BUSY] = busy;
            next_s.rdata[UFL_ST_RXL +: 8] = 8'(rx_level);
            next_s.rdata[UFL_ST_TXL +: 8] = 8'(tx_level);
          end
          default: next_s.rdata = '0; // Unmapped reads as zero.
        endcase
      end
    end else begin
      next_s.wr = 1'b1;
    end
    // Writes take effect at the edge where waitrequest is sampled low.
    if (acc_w) begin
      case (avs_address)
        UFL_DIV_LO_OFS: begin
          if (s.dlab && !busy) begin
            next_s.div[7:0] = wd;
          end
        end
        UFL_DIV_HI_OFS: begin
          if (s.dlab && !busy) begin
            next_s.div[15:8] = wd;
          end
        end
        UFL_FIFO_CTRL_OFS: begin
          next_s.rx_thr = wd[UFL_FC_RX_THR +: 2];
          next_s.tx_thr = wd[UFL_FC_TX_THR +: 2];
          next_s.dma_mode = wd[UFL_FC_DMA_MODE];
          next_s.fifo_en = wd[UFL_FC_EN];
          next_s.rx_rst = wd[UFL_FC_RX_RST] || (wd[UFL_FC_EN] != s.fifo_en);
          next_s.tx_rst = wd[UFL_FC_TX_RST] || (wd[UFL_FC_EN] != s.fifo_en);
        end
        UFL_LINE_CTRL_OFS: begin
          next_s.brk = wd[UFL_LC_BRK];
          if (!busy) begin
            next_s.dlab = wd[UFL_LC_DLAB];
            next_s.even = wd[UFL_LC_EVEN];
            next_s.par_on = wd[UFL_LC_PAR];
          end
        end
        UFL_MODEM_OFS: begin
          next_s.ir = wd[UFL_MC_IR];
          next_s.afc = wd[UFL_MC_AFC];
          next_s.loop = wd[UFL_MC_LOOP];
          next_s.rts = wd[UFL_MC_RTS];
        end
        UFL_DMA_CFG_OFS: begin
          next_s.pthre = wd[UFL_DC_PTHRE];
          next_s.ext_hs = wd[UFL_DC_EXT];
        end
        default: ; // Unmapped writes are ignored.
      endcase
    end
    // Interrupt and flow control levels.
    next_s.rx_int = rx_hit;
    next_s.thre = tx_low;
    next_s.rts_n = s.afc ? (rx_hit || !s.rts) : !s.rts;
    // Receive DMA signalling.
    next_s.rx_on = rx_go;
    if (s.rx_rst) begin
      next_s.rx_on = 1'b0;
      next_s.rx_req_n = 1'b1;
      next_s.rx_sgl_n = 1'b1;
    end else begin
      next_s.rx_req_n = (s.dma_mode || s.ext_hs) ? !rx_go : (rx_level == '0);
      next_s.rx_sgl_n = s.ext_hs ? (rx_level == '0) : 1'b1;
    end
    // Transmit DMA signalling.
    next_s.tx_on = tx_go;
    if (s.tx_rst) begin
      next_s.tx_on = 1'b0;
      next_s.tx_req_n = 1'b1;
      next_s.tx_sgl_n = 1'b1;
    end else begin
      next_s.tx_req_n = (s.dma_mode || s.ext_hs) ? !tx_go : (tx_level != '0);
      next_s.tx_sgl_n = s.ext_hs ? (tx_level == cap) : 1'b1;
    end
  end

  // State register with defined reset values.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.wr <= 1'b1;
      s.div <= UFL_DIV_RST;
      s.rts_n <= 1'b1;
      s.rx_req_n <= 1'b1;
      s.tx_req_n <= 1'b1;
      s.rx_sgl_n <= 1'b1;
      s.tx_sgl_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign avs_waitrequest = s.wr;
  assign avs_readdata = s.rdata;
  assign rx_avail_int = s.rx_int;
  assign thre_int = s.thre;
  assign rts_n = s.rts_n;
  assign dma_rx_req_n = s.rx_req_n;
  assign dma_tx_req_n = s.tx_req_n;
  assign dma_rx_single_n = s.rx_sgl_n;
  assign dma_tx_single_n = s.tx_sgl_n;
  assign parity_on_bit = s.par_on;
  assign parity_even = s.even;
  assign baud_divisor = s.div;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // A write accepted at a given offset.
  sequence fcr_wr;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == UFL_FIFO_CTRL_OFS;
  endsequence
  sequence lcr_wr;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == UFL_LINE_CTRL_OFS;
  endsequence

  rx_half_a: assert property (s.fifo_en && s.rx_thr == 2'h2 && rx_level == LW'(DEPTH / 2)
    |=> rx_avail_int) else $error("Half full not flagged.");
  rts_auto_a: assert property (s.afc && rx_hit |=> rts_n) else $error("Request to send kept.");
  rx_dma0_a: assert property (!s.ext_hs && !s.dma_mode && !s.rx_rst && rx_level != '0
    |=> !dma_rx_req_n) else $error("Receive request missing.");
  thre_two_a: assert property (s.pthre && s.fifo_en && s.tx_thr == 2'h1 && tx_level == LW'(2)
    |=> thre_int) else $error("Empty event missing.");
  tx_dma1_a: assert property (s.dma_mode && !s.tx_rst && tx_level <= tx_mark
    |=> !dma_tx_req_n) else $error("Transmit request missing.");
  tx_reset_a: assert property (fcr_wr ##0 avs_writedata[UFL_FC_TX_RST]
    |=> ##1 tx_level == '0 && dma_tx_req_n && dma_tx_single_n) else $error("Transmit reset.");
  rx_reset_a: assert property (fcr_wr ##0 avs_writedata[UFL_FC_RX_RST]
    |=> s.rx_rst ##1 !s.rx_rst && rx_level == '0 && dma_rx_req_n) else $error("Receive reset.");
  en_flip_a: assert property (fcr_wr ##0 avs_writedata[UFL_FC_EN] != s.fifo_en
    |=> ##1 rx_level == '0 && tx_level == '0) else $error("Enable change kept data.");
  busy_hold_a: assert property (lcr_wr ##0 busy
    |=> parity_on_bit == $past(parity_on_bit) && s.dlab == $past(s.dlab)) else $error("Busy write.");
endmodule

/* File: ufl_pkg.sv */
// Constants shared by the serial port FIFO and line control block.
package ufl_pkg;
  // Register byte offsets on the slave bus.
  localparam logic [7:0] UFL_DIV_LO_OFS = 8'h00; // Divisor low byte.
  localparam logic [7:0] UFL_DIV_HI_OFS = 8'h04; // Divisor high byte.
  localparam logic [7:0] UFL_FIFO_CTRL_OFS = 8'h08; // fifo_control.
  localparam logic [7:0] UFL_LINE_CTRL_OFS = 8'h0C; // line_control.
  localparam logic [7:0] UFL_MODEM_OFS = 8'h10; // modem_control_register.
  localparam logic [7:0] UFL_DMA_CFG_OFS = 8'h20; // DMA and interrupt modes.
  localparam logic [7:0] UFL_STAT_OFS = 8'h7C; // port_status_register.
  // Field positions in fifo_control.
  localparam int UFL_FC_RX_THR = 6; // Receive threshold, two bits.
  localparam int UFL_FC_TX_THR = 4; // Transmit threshold, two bits.
  localparam int UFL_FC_DMA_MODE = 3; // DMA signalling mode.
  localparam int UFL_FC_TX_RST = 2; // Transmit FIFO reset.
  localparam int UFL_FC_RX_RST = 1; // Receive FIFO reset.
  localparam int UFL_FC_EN = 0; // FIFO enable.
  // Field positions in line_control.
  localparam int UFL_LC_DLAB = 7; // Divisor access.
  localparam int UFL_LC_BRK = 6; // Break.
  localparam int UFL_LC_EVEN = 4; // Even parity sense.
  localparam int UFL_LC_PAR = 3; // parity_on_bit.
  // Field positions in modem_control_register.
  localparam int UFL_MC_IR = 6; // Infrared mode.
  localparam int UFL_MC_AFC = 5; // Automatic flow control.
  localparam int UFL_MC_LOOP = 4; // Loopback.
  localparam int UFL_MC_RTS = 1; // Request to send.
  // Field positions in the DMA configuration and status registers.
  localparam int UFL_DC_PTHRE = 0; // Programmable empty interrupt mode.
  localparam int UFL_DC_EXT = 1; // Extended DMA handshake.
  localparam int UFL_ST_BUSY = 0; // Busy.
  localparam int UFL_ST_RXL = 8; // Receive level, eight bits.
  localparam int UFL_ST_TXL = 16; // Transmit level, eight bits.
  // Reset values.
  localparam logic [7:0] UFL_CTRL_RST = 8'h00; // All control bytes.
  localparam logic [15:0] UFL_DIV_RST = 16'h0000; // Divisor.
  // Infrared break pulse timing.
  localparam int UFL_CLK_NS = 50; // System clock period.
  localparam int UFL_IR_HALF_NS = 1600; // Half period of break pulses.
  localparam int UFL_IR_HALF_CYC = UFL_IR_HALF_NS / UFL_CLK_NS; // Cycles.
endpackage

/* File: ufl_fifo_lvl.sv */
// Control portion of one character FIFO: its fill level.
module ufl_fifo_lvl import ufl_pkg::*; #(
  parameter int DEPTH = 16, // Capacity in characters.
  parameter int LW = 5 // Level width.
) (
  input wire logic clk_sys, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic clr, // Empties the FIFO.
  input wire logic push, // One character enters.
  input wire logic pop, // One character leaves.
  input wire logic [LW-1:0] cap, // Capacity in use.
  output logic [LW-1:0] level // Characters held.
);
  typedef struct packed {
    logic [LW-1:0] lvl; // Fill level.
  } ufl_lvl_s;
  ufl_lvl_s s, next_s; // State and its next value.
  logic ins, del; // Accepted push and pop.

  // A clear wins over any push or pop of the same cycle.
  always_comb begin
    next_s = s;
    ins = push && (s.lvl < cap);
    del = pop && (s.lvl != '0);
    if (clr) begin
      next_s.lvl = '0;
    end else if (ins && !del) begin
      next_s.lvl = s.lvl + 1'b1;
    end else if (del && !ins) begin
      next_s.lvl = s.lvl - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  clear_empty_a: assert property (clr |=> level == '0) else $error("Clear left data.");
  level_up_a: assert property (!clr && push && !pop && level < cap |=> level == $past(level) + 1'b1)
    else $error("Push not counted.");
endmodule

/* File: ufl_line_out.sv */
// Serial and infrared output stage with break and loopback.
module ufl_line_out import ufl_pkg::*; #(
  parameter int HALF = UFL_IR_HALF_CYC // Cycles per half pulse.
) (
  input wire logic clk_sys, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic tx_bit, // Transmitter line level.
  input wire logic brk, // Break requested.
  input wire logic loop, // Loopback mode.
  input wire logic ir_on, // Infrared mode.
  output logic ser_out, // Serial output.
  output logic ir_out_n, // Infrared output, pulses low.
  output logic loop_line // Line fed to the receiver in loopback.
);
  localparam int CW = $clog2(HALF + 1); // Divider width.
  typedef struct packed {
    logic [CW-1:0] cnt; // Pulse divider.
    logic ser; // Serial output.
    logic ir_n; // Infrared output.
    logic lb; // Loopback line.
  } ufl_line_s;
  ufl_line_s s, next_s; // State and its next value.
  logic tick; // Half period elapsed.

  // Output selection by mode, loopback first.
  always_comb begin
    next_s = s;
    tick = (s.cnt == '0);
    next_s.cnt = tick ? CW'(HALF - 1) : s.cnt - 1'b1;
    if (loop) begin
      next_s.ser = 1'b1; // Line stays idle in loopback.
      next_s.ir_n = 1'b0;
      next_s.lb = brk ? 1'b0 : tx_bit;
    end else if (brk) begin
      next_s.ser = 1'b0;
      next_s.lb = 1'b1;
      next_s.ir_n = ir_on ? (tick ? !s.ir_n : s.ir_n) : 1'b1;
    end else begin
      next_s.ser = ir_on ? 1'b1 : tx_bit;
      next_s.ir_n = 1'b1;
      next_s.lb = 1'b1;
    end
  end

  // State register, idle mark level from reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{cnt: '0, ser: 1'b1, ir_n: 1'b1, lb: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign ser_out = s.ser;
  assign ir_out_n = s.ir_n;
  assign loop_line = s.lb;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  break_low_a: assert property (brk && !loop |=> !ser_out) else $error("Break not low.");
  ir_pulse_a: assert property (brk && ir_on && !loop && tick ##1 brk && ir_on && !loop
    |-> ir_out_n != $past(ir_out_n)) else $error("No break pulse.");
  loop_ir_a: assert property (loop |=> !ir_out_n && ser_out) else $error("Loop output wrong.");
  idle_a: assert property (!brk && !loop && !ir_on |=> ser_out == $past(tx_bit))
    else $error("Line not released.");
endmodule

/* File: ufl_far_end.sv */
// Far-end serial device model that watches the serial and infrared lines.
module ufl_far_end (
  input wire logic clk_sys, // System clock.
  input wire logic ser_out, // Serial line from the port.
  input wire logic ir_out_n, // Infrared line from the port.
  output logic tx_bit, // Transmitter level.
  output int low_run, // Consecutive spacing cycles.
  output int ir_edges // Infrared transitions.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ir_last = 1'b1; // Previous infrared level.
  // An idle transmitter rests at mark.
  assign tx_bit = 1'b1;
  // Counters start clear.
  initial begin
    low_run = 0;
    ir_edges = 0;
  end
  // A held break shows as a long run of spacing cycles.
  always @(posedge clk_sys) begin
    low_run <= (ser_out === 1'b0) ? low_run + 1 : 0;
    ir_edges <= ir_edges + int'(ir_out_n !== ir_last);
    ir_last <= ir_out_n;
  end
endmodule

/* File: ufl_top_tb_top.sv */
// Self-checking bench for the serial port FIFO and line control block.
module ufl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ufl_pkg::*;
  localparam int DP = 16; // Depth under test.
  localparam int IRH = 2; // Short infrared half period.
  logic clk_sys = 1'b0; // System clock.
  logic resetn = 1'b0; // Reset, active low.
  logic [7:0] avs_address = 8'h00; // Bus address.
  logic avs_read = 1'b0; // Read request.
  logic avs_write = 1'b0; // Write request.
  logic [31:0] avs_writedata = 32'h0; // Write data.
  logic [3:0] avs_byteenable = 4'hF; // All lanes on.
  logic busy = 1'b0; // Port busy level.
  logic rx_push = 1'b0, rx_pop = 1'b0, tx_push = 1'b0, tx_pop = 1'b0; // Strobes.
  logic [31:0] avs_readdata, q; // Read data and last read.
  logic avs_waitrequest, tx_bit, rx_avail_int, thre_int, rts_n, ser_out, ir_out_n, loop_line; // Lines.
  logic dma_rx_req_n, dma_tx_req_n, dma_rx_single_n, dma_tx_single_n, parity_on_bit, parity_even; // Flags.
  logic [4:0] rx_level, tx_level; // Fill levels.
  logic [15:0] baud_divisor; // Divisor.
  int ir_edges, low_run, fail_count = 0, comparisons = 0; // Model counts and tallies.
  // Device under test.
  ufl_top #(.DEPTH(DP), .LW(5), .IR_HALF(IRH)) dut (.clk_sys, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .busy, .rx_push,
    .rx_pop, .tx_push, .tx_pop, .tx_bit, .rx_level, .tx_level, .rx_avail_int, .thre_int, .rts_n,
    .dma_rx_req_n, .dma_tx_req_n, .dma_rx_single_n, .dma_tx_single_n, .ser_out, .ir_out_n,
    .loop_line, .parity_on_bit, .parity_even, .baud_divisor);
  // Far side of the serial line.
  ufl_far_end far (.clk_sys, .ser_out, .ir_out_n, .tx_bit, .low_run, .ir_edges);
  // Clock of 50 ns period.
  initial forever #25 clk_sys = ~clk_sys;
  // Compares one value and tallies the outcome.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Prints the tallies and the verdict, then ends the run.
  task automatic close_out();
    $display("Mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One bus cycle held until waitrequest is sampled low, then settling edges.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        fail_count++;
        close_out();
      end
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Strobe k (0 rx push, 1 rx pop, 2 tx push, 3 tx pop) for n cycles.
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      {tx_pop, tx_push, rx_pop, rx_push} <= 4'h1 << k;
      @(posedge clk_sys);
    end
    {tx_pop, tx_push, rx_pop, rx_push} <= 4'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Each receive trigger code, with flow control and the mode 1 request.
  task automatic rx_thr();
    int mk[4] = '{1, DP / 4, DP / 2, DP - 2};
    bus(UFL_MODEM_OFS, 1'b1, 8'h22);
    for (int c = 0; c < 4; c++) begin
      bus(UFL_FIFO_CTRL_OFS, 1'b1, 8'(c << 6) | 8'h0F);
      pulse(0, mk[c] - 1);
      chk("rx int below", 0, rx_avail_int);
      chk("rts below", 0, rts_n);
      chk("rx req below", 1, dma_rx_req_n);
      pulse(0, 1);
      chk("rx level", mk[c], rx_level);
      chk("rx int at", 1, rx_avail_int);
      chk("rts at", 1, rts_n);
      chk("rx req at", 0, dma_rx_req_n);
    end
    bus(UFL_MODEM_OFS, 1'b1, 8'h00);
  endtask
  // Each transmit trigger code in programmable empty mode, DMA mode 0.
  task automatic tx_thr();
    int mk[4] = '{0, 2, DP / 4, DP / 2};
    bus(UFL_DMA_CFG_OFS, 1'b1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      bus(UFL_FIFO_CTRL_OFS, 1'b1, 8'(c << 4) | 8'h07);
      pulse(2, mk[c] + 1);
      chk("thre above", 0, thre_int);
      chk("tx req held", 1, dma_tx_req_n);
      pulse(3, 1);
      chk("tx level", mk[c], tx_level);
      chk("thre at", 1, thre_int);
      chk("tx req empty", mk[c] != 0, dma_tx_req_n);
    end
    // Mode 0 receive request asks as soon as one character waits.
    pulse(0, 1);
    chk("rx req mode 0", 0, dma_rx_req_n);
  endtask
  // FIFO resets one at a time, self-clearing, then enable change.
  task automatic fifo_rst();
    bus(UFL_DMA_CFG_OFS, 1'b1, 8'h02);
    bus(UFL_FIFO_CTRL_OFS, 1'b1, 8'h07);
    pulse(0, 3);
    pulse(2, 3);
    chk("rx single on", 0, dma_rx_single_n);
    chk("tx single on", 0, dma_tx_single_n);
    bus(UFL_FIFO_CTRL_OFS, 1'b1, 8'h03);
    chk("rx cleared", 0, rx_level);
    chk("tx kept", 3, tx_level);
    chk("rx single off", 1, dma_rx_single_n);
    bus(UFL_FIFO_CTRL_OFS, 1'b1, 8'h05);
    chk("tx cleared", 0, tx_level);
    pulse(2, 2);
    pulse(0, 2);
    chk("tx self clear", 2, tx_level);
    bus(UFL_STAT_OFS, 1'b0, 8'h00);
    chk("status levels", 32'h00020200, q);
    bus(UFL_FIFO_CTRL_OFS, 1'b0, 8'h00);
    chk("fifos on", 32'hC0, q);
    bus(UFL_FIFO_CTRL_OFS, 1'b1, 8'h00);
    chk("enable rx", 0, rx_level);
    chk("enable tx", 0, tx_level);
    bus(UFL_DMA_CFG_OFS, 1'b1, 8'h00);
  endtask
  // Divisor access, busy gating, parity, break, infrared and loopback.
  task automatic line_ctl();
    int n;
    bus(UFL_DIV_LO_OFS, 1'b1, 8'h34);
    chk("div closed", 0, baud_divisor);
    bus(UFL_LINE_CTRL_OFS, 1'b1, 8'h98);
    bus(UFL_DIV_LO_OFS, 1'b1, 8'h34);
    bus(UFL_DIV_HI_OFS, 1'b1, 8'h12);
    chk("div open", 16'h1234, baud_divisor);
    bus(UFL_DIV_HI_OFS, 1'b0, 8'h00);
    chk("div read", 32'h12, q);
    chk("even on", 1, parity_even);
    busy <= 1'b1;
    bus(UFL_LINE_CTRL_OFS, 1'b1, 8'h40);
    bus(UFL_LINE_CTRL_OFS, 1'b0, 8'h00);
    chk("busy kept", 32'hD8, q);
    chk("parity kept", 1, parity_on_bit);
    chk("break low", 0, ser_out);
    // The run count lags the line by one edge, so let the break stand a little longer.
    repeat (2) @(posedge clk_sys);
    chk("break held", 1, low_run > 6);
    busy <= 1'b0;
    bus(UFL_LINE_CTRL_OFS, 1'b1, 8'h08);
    chk("odd sense", 0, parity_even);
    chk("idle after", 1, ser_out);
    bus(UFL_DIV_HI_OFS, 1'b0, 8'h00);
    chk("div shut", 0, q);
    bus(UFL_LINE_CTRL_OFS, 1'b1, 8'h00);
    chk("parity off", 0, parity_on_bit);
    bus(UFL_MODEM_OFS, 1'b1, 8'h40);
    bus(UFL_LINE_CTRL_OFS, 1'b1, 8'h40);
    n = ir_edges;
    repeat (20) @(posedge clk_sys);
    chk("ir pulses", 1, (ir_edges - n) inside {[9:11]});
    bus(UFL_MODEM_OFS, 1'b1, 8'h50);
    chk("loop ir low", 0, ir_out_n);
    chk("loop ser", 1, ser_out);
    chk("loop break", 0, loop_line);
    bus(UFL_LINE_CTRL_OFS, 1'b1, 8'h00);
    chk("loop idle", 1, loop_line);
    bus(UFL_MODEM_OFS, 1'b1, 8'h00);
  endtask
  // Main sequence: reset, reset values, unmapped place, then the scenarios.
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    bus(UFL_FIFO_CTRL_OFS, 1'b0, 8'h00);
    chk("fifo ctrl reset", 0, q);
    bus(UFL_LINE_CTRL_OFS, 1'b0, 8'h00);
    chk("line ctrl reset", 0, q);
    bus(8'h40, 1'b1, 8'hFF);
    bus(8'h40, 1'b0, 8'h00);
    chk("unmapped", 0, q);
    rx_thr();
    tx_thr();
    fifo_rst();
    line_ctl();
    close_out();
  end
endmodule
